// ### rtl/prx_pkg.sv
// Notes on behaviour
// [RQ1] mii receive clock runs 25 MHz at 100 Mbps, 2.5 MHz at 10 Mbps; the divider gives 20 MHz at 100 Mbps
// [RQ2] in rmii the receive clock pin is unused and not driven
// [RQ3] regulator-off strap on receive clock pin: high disables the core regulator
// [RQ4] mii collision output follows detected medium collision
// [RQ5] mii/rmii choice captured from collision pin at reset release, then held
// [RQ6] low or floating mode strap gives mii, high gives rmii
// [RQ7] rmii crs_dv is high while the receive medium is not idle
// [RQ8] rmii 10 Mbps: crs_dv at carrier, data low until start delimiter seen
// [RQ9] rmii 10 Mbps half duplex: mac transmit data never loops to receive data
// [RQ10] mii carrier-sense output follows detected carrier
// [RQ11] speed indicator active at 100 Mbps, inactive at 10 Mbps
// [RQ12] link indicator active while a link is up at either speed
// [RQ13] traffic indicator active while carrier is present
// [RQ14] duplex indicator active in full duplex, inactive in half
// [RQ15] speed, link, traffic, duplex, carrier pins strap address bits 0 to 4
// [RQ16] captured address bits form the default management address
// [RQ17] strap pins are inputs only in reset, outputs after, values held; the carrier-sense and receive clock pins stay inputs in rmii
package prx_pkg;

    // ==================================================
    // clocking
    localparam int unsigned CLK_HZ        = 40_000_000;
    localparam int unsigned RXCLK_FAST_HZ = 25_000_000;
    localparam int unsigned RXCLK_SLOW_HZ = 2_500_000;
    // half period, rounded down, never below one cycle
    localparam int unsigned HALF_FAST_RAW = CLK_HZ / (2 * RXCLK_FAST_HZ);
    localparam int unsigned HALF_SLOW_RAW = CLK_HZ / (2 * RXCLK_SLOW_HZ);
    localparam logic [7:0]  HALF_FAST     = 8'(HALF_FAST_RAW < 1 ? 1 : HALF_FAST_RAW);
    localparam logic [7:0]  HALF_SLOW     = 8'(HALF_SLOW_RAW < 1 ? 1 : HALF_SLOW_RAW);

    // ==================================================
    // start-of-frame delimiter
    localparam logic [7:0]  SFD_PATTERN   = 8'hab;

    // ==================================================
    // register map (byte addresses)
    localparam logic [7:0]  ADDR_STATUS   = 8'h00;
    localparam logic [7:0]  ADDR_MASK     = 8'h04;
    localparam logic [7:0]  ADDR_STRAP    = 8'h08;
    localparam logic [7:0]  ADDR_LIVE     = 8'h0c;

    // status / mask bits
    localparam int unsigned EV_W          = 5;
    localparam int unsigned EV_LINK       = 0;
    localparam int unsigned EV_SPEED      = 1;
    localparam int unsigned EV_DUPLEX     = 2;
    localparam int unsigned EV_COLL       = 3;
    localparam int unsigned EV_SFD        = 4;
    localparam logic [EV_W-1:0] MASK_RST  = 5'h00;

    // strap register fields
    localparam int unsigned ST_ADDR_LSB   = 0;
    localparam int unsigned ST_RMII       = 5;
    localparam int unsigned ST_REGULATOR_DISABLE_STRAP     = 6;

    // live register fields
    localparam int unsigned LV_LINK       = 0;
    localparam int unsigned LV_SPEED      = 1;
    localparam int unsigned LV_DUPLEX     = 2;
    localparam int unsigned LV_CARRIER    = 3;
    localparam int unsigned LV_COLL       = 4;

    typedef enum logic {
        PRX_SAMPLE,
        PRX_RUN
    } prx_phase_t;

endpackage : prx_pkg

// ### rtl/prx_phy_rx_status.sv
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module prx_phy_rx_status
    import prx_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        srst_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    output logic             irq_o,
    // internal phy core state, same clock
    input  wire logic        link_up_i,
    input  wire logic        speed_fast_i,
    input  wire logic        full_duplex_i,
    input  wire logic        carrier_i,
    input  wire logic        collision_i,
    input  wire logic        mac_tx_en_i,
    input  wire logic [1:0]  rx_dibit_i,
    // recovered line clock and bit, foreign domain
    input  wire logic        line_clk_i,
    input  wire logic        line_bit_i,
    // rmii receive data
    output logic      [1:0]  rxd_o,
    // receive clock / regulator-off strap pin
    input  wire logic        rx_clk_i,
    output logic             rx_clk_o,
    output logic             rx_clk_oe_o,
    // collision / mode strap / crs_dv pin
    input  wire logic        col_crsdv_i,
    output logic             col_crsdv_o,
    output logic             col_crsdv_oe_o,
    // indicator and address strap pins
    input  wire logic        fast_speed_indicator_i,
    output logic             fast_speed_indicator_o,
    output logic             fast_speed_indicator_oe_o,
    input  wire logic        link_indicator_i,
    output logic             link_indicator_o,
    output logic             link_indicator_oe_o,
    input  wire logic        traffic_indicator_i,
    output logic             traffic_indicator_o,
    output logic             traffic_indicator_oe_o,
    input  wire logic        full_duplex_indicator_i,
    output logic             full_duplex_indicator_o,
    output logic             full_duplex_indicator_oe_o,
    input  wire logic        carrier_sense_i,
    output logic             carrier_sense_o,
    output logic             carrier_sense_oe_o,
    // captured configuration
    output logic      [4:0]  phy_addr_o,
    output logic             rmii_mode_o,
    output logic             regulator_disable_strap_o
);

    // ==================================================
    // pin synchronisers
    logic [8:0] sy1_q, sy1_d, sy2_q, sy2_d;
    logic       lclk_prev_q, lclk_prev_d;

    always_comb begin
        sy1_d = {line_bit_i, line_clk_i, rx_clk_i, col_crsdv_i, carrier_sense_i,
                 full_duplex_indicator_i, traffic_indicator_i, link_indicator_i,
                 fast_speed_indicator_i};
        sy2_d       = sy1_q;
        lclk_prev_d = sy2_q[7];
    end

    always_ff @(posedge clk_sys_i) begin
        sy1_q       <= sy1_d;
        sy2_q       <= sy2_d;
        lclk_prev_q <= lclk_prev_d;
    end

    logic line_rise;
    assign line_rise = sy2_q[7] & ~lclk_prev_q;

    // ==================================================
    // strap capture
    prx_phase_t phase_q, phase_d;
    logic [4:0] addr_q, addr_d;
    logic       rmii_q, rmii_d;
    logic       regulator_disable_strap_q, regulator_disable_strap_d;

    always_comb begin
        phase_d  = phase_q;
        addr_d   = addr_q;
        rmii_d   = rmii_q;
        regulator_disable_strap_d = regulator_disable_strap_q;
        case (phase_q)
            // first cycle after release: pins still undriven by us
            PRX_SAMPLE: begin
                addr_d   = sy2_q[4:0];    // [RQ15] [RQ16]
                rmii_d   = sy2_q[5];      // [RQ5] [RQ6]
                regulator_disable_strap_d = sy2_q[6];      // [RQ3]
                phase_d  = PRX_RUN;
            end
            PRX_RUN: begin
                phase_d  = PRX_RUN;       // [RQ17]
            end
            default: begin
                phase_d  = PRX_SAMPLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            phase_q  <= PRX_SAMPLE;
            addr_q   <= 5'h00;
            rmii_q   <= 1'b0;
            regulator_disable_strap_q <= 1'b0;
        end else begin
            phase_q  <= phase_d;
            addr_q   <= addr_d;
            rmii_q   <= rmii_d;
            regulator_disable_strap_q <= regulator_disable_strap_d;
        end
    end

    logic run;
    assign run = (phase_q == PRX_RUN);

    // ==================================================
    // receive clock divider and delimiter hunt
    logic [7:0] div_q, div_d;
    logic       rck_q, rck_d;
    logic [7:0] shf_q, shf_d;
    logic       sfd_q, sfd_d;
    logic       sfd_hit;

    always_comb begin
        div_d   = div_q;
        rck_d   = rck_q;
        shf_d   = shf_q;
        sfd_d   = sfd_q;
        sfd_hit = 1'b0;
        if (rmii_q) begin
            div_d = 8'h00;
            rck_d = 1'b0;                                          // [RQ2]
        end else if (div_q + 8'h01 >= (speed_fast_i ? HALF_FAST : HALF_SLOW)) begin
            div_d = 8'h00;
            rck_d = ~rck_q;                                        // [RQ1]
        end else begin
            div_d = div_q + 8'h01;
        end
        if (!carrier_i) begin
            shf_d = 8'h00;
            sfd_d = 1'b0;
        end else if (line_rise && !sfd_q) begin
            shf_d = {shf_q[6:0], sy2_q[8]};
            if ({shf_q[6:0], sy2_q[8]} == SFD_PATTERN) begin       // [RQ8]
                sfd_d   = 1'b1;
                sfd_hit = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            div_q <= 8'h00;
            rck_q <= 1'b0;
            shf_q <= 8'h00;
            sfd_q <= 1'b0;
        end else begin
            div_q <= div_d;
            rck_q <= rck_d;
            shf_q <= shf_d;
            sfd_q <= sfd_d;
        end
    end

    // ==================================================
    // pin outputs, all registered
    logic [1:0] rxd_d;
    logic       col_d, crs_d;
    logic       loop_block;

    // half duplex 10M: our own transmit must not reach the mac receive side
    assign loop_block = ~speed_fast_i & ~full_duplex_i & mac_tx_en_i;

    always_comb begin
        rxd_d = 2'b00;
        if (rmii_q && carrier_i && !loop_block) begin               // [RQ9]
            if (speed_fast_i || sfd_q) begin
                rxd_d = rx_dibit_i;                                 // [RQ8]
            end
        end
        col_d = rmii_q ? carrier_i : collision_i;                   // [RQ4] [RQ7]
        crs_d = carrier_i;                                          // [RQ10]
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            rxd_o                      <= 2'b00;
            rx_clk_o                   <= 1'b0;
            rx_clk_oe_o                <= 1'b0;
            col_crsdv_o                <= 1'b0;
            col_crsdv_oe_o             <= 1'b0;
            fast_speed_indicator_o     <= 1'b0;
            fast_speed_indicator_oe_o  <= 1'b0;
            link_indicator_o           <= 1'b0;
            link_indicator_oe_o        <= 1'b0;
            traffic_indicator_o        <= 1'b0;
            traffic_indicator_oe_o     <= 1'b0;
            full_duplex_indicator_o    <= 1'b0;
            full_duplex_indicator_oe_o <= 1'b0;
            carrier_sense_o            <= 1'b0;
            carrier_sense_oe_o         <= 1'b0;
            phy_addr_o                 <= 5'h00;
            rmii_mode_o                <= 1'b0;
            regulator_disable_strap_o  <= 1'b0;
        end else begin
            rxd_o                      <= run ? rxd_d : 2'b00;
            rx_clk_o                   <= rck_q;
            rx_clk_oe_o                <= run & ~rmii_q;            // [RQ2] [RQ17]
            col_crsdv_o                <= col_d;
            col_crsdv_oe_o             <= run;                      // [RQ17]
            fast_speed_indicator_o     <= speed_fast_i;             // [RQ11]
            fast_speed_indicator_oe_o  <= run;
            link_indicator_o           <= link_up_i;                // [RQ12]
            link_indicator_oe_o        <= run;
            traffic_indicator_o        <= carrier_i;                // [RQ13]
            traffic_indicator_oe_o     <= run;
            full_duplex_indicator_o    <= full_duplex_i;            // [RQ14]
            full_duplex_indicator_oe_o <= run;
            carrier_sense_o            <= crs_d;
            carrier_sense_oe_o         <= run & ~rmii_q;            // [RQ17]
            phy_addr_o                 <= addr_q;                   // [RQ16]
            rmii_mode_o                <= rmii_q;
            regulator_disable_strap_o  <= regulator_disable_strap_q;                 // [RQ3]
        end
    end

    // ==================================================
    // apb registers and interrupt
    logic [EV_W-1:0] stat_q, stat_d, mask_q, mask_d, ev;
    logic [2:0]      prev_q, prev_d;
    logic [31:0]     rdata_d;
    logic            rdy_d, err_d, irq_d, mapped, done;

    always_comb begin
        ev            = '0;
        ev[EV_LINK]   = run & (link_up_i     ^ prev_q[0]);
        ev[EV_SPEED]  = run & (speed_fast_i  ^ prev_q[1]);
        ev[EV_DUPLEX] = run & (full_duplex_i ^ prev_q[2]);
        ev[EV_COLL]   = run & collision_i & ~rmii_q;
        ev[EV_SFD]    = sfd_hit;
        prev_d        = {full_duplex_i, speed_fast_i, link_up_i};
        mapped = (paddr_i == ADDR_STATUS) || (paddr_i == ADDR_MASK) ||
                 (paddr_i == ADDR_STRAP)  || (paddr_i == ADDR_LIVE);
        done   = psel_i & penable_i & pready_o;
        rdy_d  = psel_i & ~penable_i;
        err_d  = psel_i & ~penable_i & ~mapped;
        rdata_d = 32'h0000_0000;
        case (paddr_i)
            ADDR_STATUS: rdata_d[EV_W-1:0] = stat_q;
            ADDR_MASK:   rdata_d[EV_W-1:0] = mask_q;
            ADDR_STRAP: begin
                rdata_d[ST_ADDR_LSB +: 5] = addr_q;
                rdata_d[ST_RMII]          = rmii_q;
                rdata_d[ST_REGULATOR_DISABLE_STRAP]        = regulator_disable_strap_q;
            end
            ADDR_LIVE: begin
                rdata_d[LV_LINK]    = link_up_i;
                rdata_d[LV_SPEED]   = speed_fast_i;
                rdata_d[LV_DUPLEX]  = full_duplex_i;
                rdata_d[LV_CARRIER] = carrier_i;
                rdata_d[LV_COLL]    = collision_i;
            end
            default: rdata_d = 32'h0000_0000;
        endcase
        if (!(psel_i && !penable_i && !pwrite_i)) begin
            rdata_d = prdata_o;
        end
        mask_d = mask_q;
        if (done && pwrite_i && paddr_i == ADDR_MASK) begin
            mask_d = pwdata_i[EV_W-1:0];
        end
        stat_d = stat_q;
        // clear only what the read reported, so a setup-cycle event is kept
        if (done && !pwrite_i && paddr_i == ADDR_STATUS) begin
            stat_d = stat_q & ~prdata_o[EV_W-1:0];
        end
        // a new event in the clearing cycle survives
        stat_d = stat_d | ev;
        irq_d  = |(stat_d & mask_d);
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            stat_q    <= '0;
            mask_q    <= MASK_RST;
            prev_q    <= 3'b000;
            prdata_o  <= 32'h0000_0000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            irq_o     <= 1'b0;
        end else begin
            stat_q    <= stat_d;
            mask_q    <= mask_d;
            prev_q    <= prev_d;
            prdata_o  <= rdata_d;
            pready_o  <= rdy_d;
            pslverr_o <= err_d;
            irq_o     <= irq_d;
        end
    end

endmodule : prx_phy_rx_status
`default_nettype wire

// ### tb/prx_props.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// port checker
module prx_props
    import prx_pkg::*;
(
    input wire logic       clk_sys_i,
    input wire logic       srst_i,
    input wire logic       psel_i,
    input wire logic       penable_i,
    input wire logic [7:0] paddr_i,
    input wire logic       pready_o,
    input wire logic       pslverr_o,
    input wire logic       collision_i,
    input wire logic       carrier_i,
    input wire logic       speed_fast_i,
    input wire logic       link_up_i,
    input wire logic       full_duplex_i,
    input wire logic [1:0] rxd_o,
    input wire logic       rx_clk_oe_o,
    input wire logic       col_crsdv_o,
    input wire logic       fast_speed_indicator_o,
    input wire logic       fast_speed_indicator_oe_o,
    input wire logic       link_indicator_o,
    input wire logic       traffic_indicator_o,
    input wire logic       full_duplex_indicator_o,
    input wire logic       carrier_sense_o,
    input wire logic [4:0] phy_addr_o,
    input wire logic       rmii_mode_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    // pins count as outputs only from the second cycle of run
    wire run = fast_speed_indicator_oe_o;
    sequence s_setup; psel_i && !penable_i; endsequence
    sequence s_answer; pready_o ##1 !pready_o; endsequence

    a_apb_answer: assert property (s_setup |=> s_answer)
        else $error("apb answer not one cycle after setup");
    a_unmapped_err: assert property (psel_i && !penable_i && paddr_i > ADDR_LIVE |=> pslverr_o)
        else $error("unmapped access without error");
    a_coll_follow: assert property (run && $past(run) && !rmii_mode_o
        |-> col_crsdv_o == $past(collision_i)) else $error("collision pin wrong");
    a_crsdv_carrier: assert property (run && $past(run) && rmii_mode_o
        |-> col_crsdv_o == $past(carrier_i)) else $error("crs_dv pin wrong");
    a_crs_follow: assert property (run && $past(run) && !rmii_mode_o
        |-> carrier_sense_o == $past(carrier_i)) else $error("carrier pin wrong");
    a_leds_follow: assert property (run && $past(run)
        |-> {fast_speed_indicator_o, link_indicator_o, traffic_indicator_o,
             full_duplex_indicator_o}
            == $past({speed_fast_i, link_up_i, carrier_i, full_duplex_i}))
        else $error("indicator wrong");
    a_straps_held: assert property (run && $past(run)
        |-> $stable(phy_addr_o) && $stable(rmii_mode_o)) else $error("strap value moved");
    a_rmii_no_clk: assert property (rmii_mode_o |-> !rx_clk_oe_o)
        else $error("receive clock driven in rmii");
    a_rxd_quiet: assert property (rmii_mode_o && !$past(speed_fast_i)
        && !$past(carrier_i) && !$past(carrier_i, 2) |-> rxd_o == 2'h0)
        else $error("rxd not low");
endmodule : prx_props

bind prx_phy_rx_status prx_props u_prx_props (
    .clk_sys_i, .srst_i, .psel_i, .penable_i, .paddr_i, .pready_o, .pslverr_o, .collision_i,
    .carrier_i, .speed_fast_i, .link_up_i, .full_duplex_i, .rxd_o, .rx_clk_oe_o, .col_crsdv_o,
    .fast_speed_indicator_o, .fast_speed_indicator_oe_o, .link_indicator_o, .traffic_indicator_o,
    .full_duplex_indicator_o, .carrier_sense_o, .phy_addr_o, .rmii_mode_o
);
`default_nettype wire

// ### tb/prx_mac_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// board resistors and mac side of the shared pins
module prx_mac_model (
    input  wire logic [6:0] pin_o_i,
    input  wire logic [6:0] pin_oe_i,
    input  wire logic [6:0] strap_i,
    output logic      [6:0] pin_lvl_o,
    output logic            mac_rx_clk_o
);
    // resistor level shows only while the phy leaves the pin alone
    assign pin_lvl_o = (pin_o_i & pin_oe_i) | (strap_i & ~pin_oe_i);
    // mac ignores the receive clock pin unless it is driven
    assign mac_rx_clk_o = pin_oe_i[6] & pin_lvl_o[6];
endmodule : prx_mac_model
`default_nettype wire

// ### tb/tb_prx_phy_rx_status.sv
`timescale 1ns/1ps
`default_nettype none
module tb_prx_phy_rx_status;
    import prx_pkg::*;
    // ==================================================
    // stimulus and pins
    logic        clk_sys_i = 1'b0;
    logic        srst_i = 1'b1;
    logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic        link_up_i = 1'b0, speed_fast_i = 1'b0, full_duplex_i = 1'b0;
    logic        carrier_i = 1'b0, collision_i = 1'b0, mac_tx_en_i = 1'b0;
    logic [1:0]  rx_dibit_i = 2'h0;
    logic        line_clk_i = 1'b0, line_bit_i = 1'b0;
    logic [6:0]  strap = 7'h00, cfg;
    wire  [31:0] prdata_o;
    wire         pready_o, pslverr_o, irq_o, rmii_mode_o, regulator_disable_strap_o, mac_clk;
    wire  [1:0]  rxd_o;
    wire  [4:0]  phy_addr_o;
    wire  [6:0]  po, poe, pin;
    int          n_errors = 0, checks = 0;
    logic [31:0] rd_v;
    logic        rd_e;

    always #12.5 clk_sys_i = ~clk_sys_i;

    prx_phy_rx_status u_prx_phy_rx_status (
        .clk_sys_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .prdata_o, .pready_o, .pslverr_o, .irq_o, .link_up_i, .speed_fast_i,
        .full_duplex_i, .carrier_i, .collision_i, .mac_tx_en_i, .rx_dibit_i,
        .line_clk_i, .line_bit_i, .rxd_o, .rmii_mode_o, .regulator_disable_strap_o, .phy_addr_o,
        .fast_speed_indicator_i(pin[0]), .fast_speed_indicator_o(po[0]),
        .fast_speed_indicator_oe_o(poe[0]), .link_indicator_i(pin[1]),
        .link_indicator_o(po[1]), .link_indicator_oe_o(poe[1]),
        .traffic_indicator_i(pin[2]), .traffic_indicator_o(po[2]),
        .traffic_indicator_oe_o(poe[2]), .full_duplex_indicator_i(pin[3]),
        .full_duplex_indicator_o(po[3]), .full_duplex_indicator_oe_o(poe[3]),
        .carrier_sense_i(pin[4]), .carrier_sense_o(po[4]), .carrier_sense_oe_o(poe[4]),
        .col_crsdv_i(pin[5]), .col_crsdv_o(po[5]), .col_crsdv_oe_o(poe[5]),
        .rx_clk_i(pin[6]), .rx_clk_o(po[6]), .rx_clk_oe_o(poe[6])
    );
    prx_mac_model u_prx_mac_model (.pin_o_i(po), .pin_oe_i(poe), .strap_i(strap),
        .pin_lvl_o(pin), .mac_rx_clk_o(mac_clk));

    // ==================================================
    // tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        // answer is taken at the edge that samples pready high
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (pready_o !== 1'b1) chk(pready_o, 1'b1);
        rd_v = prdata_o;
        rd_e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd_v, exp);
    endtask : rd

    // link clock only runs while a bit is on the line
    task automatic bit_in(input logic b);
        line_bit_i <= b;
        repeat (4) @(posedge clk_sys_i);
        line_clk_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        line_clk_i <= 1'b0;
    endtask : bit_in

    task automatic rx_half(input int exp);
        logic v;
        int   n;
        @(posedge clk_sys_i);
        #1 v = po[6];
        n = 0;
        while (po[6] === v && n < 40) begin
            @(posedge clk_sys_i);
            #1 n++;
        end
        v = po[6];
        n = 0;
        while (po[6] === v && n < 40) begin
            @(posedge clk_sys_i);
            #1 n++;
        end
        chk(n, exp);
    endtask : rx_half

    task automatic give_verdict();
        if (n_errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict

    initial begin
        #500us n_errors++;
        give_verdict();
    end

    // ==================================================
    // tests: mii with regulator off, then rmii after a second reset
    initial begin
        for (int m = 0; m < 2; m++) begin
            cfg = m ? 7'h2a : 7'h55;
            strap <= cfg;
            srst_i <= 1'b1;
            repeat (20) @(posedge clk_sys_i);
            srst_i <= 1'b0;
            repeat (3) @(posedge clk_sys_i);
            chk(phy_addr_o, cfg[4:0]);
            chk(rmii_mode_o, cfg[5]);
            chk(regulator_disable_strap_o, cfg[6]);
            rd(ADDR_STRAP, {25'h0, cfg});
            rd(ADDR_MASK, 32'h0);
            rd(8'h40, 32'h0);
            chk(rd_e, 1'b1);
            rd(ADDR_STATUS, 32'h0);
            if (m == 0) begin
                apb(1'b1, ADDR_MASK, 32'hffffffff);
                rd(ADDR_MASK, 32'h1f);
                apb(1'b1, ADDR_MASK, 32'h0);
                collision_i <= 1'b1;
                repeat (3) @(posedge clk_sys_i);
                #1 chk(po[5], 1'b1);
                chk(irq_o, 1'b0);
                @(posedge clk_sys_i);
                collision_i <= 1'b0;
                apb(1'b1, ADDR_MASK, 32'h8);
                repeat (2) @(posedge clk_sys_i);
                #1 chk(irq_o, 1'b1);
                rd(ADDR_STATUS, 32'h8);
                repeat (2) @(posedge clk_sys_i);
                #1 chk(irq_o, 1'b0);
                for (int i = 0; i < 16; i++) begin
                    @(posedge clk_sys_i);
                    {carrier_i, full_duplex_i, speed_fast_i, link_up_i} <= i[3:0];
                    repeat (3) @(posedge clk_sys_i);
                    #1 chk(pin[4:0], {i[3], i[2], i[3], i[0], i[1]});
                    rd(ADDR_LIVE, {28'h0, i[3:0]});
                end
                rd(ADDR_STATUS, 32'h7);
                rx_half(HALF_FAST);
                @(posedge clk_sys_i);
                speed_fast_i <= 1'b0;
                rx_half(HALF_SLOW);
            end else begin
                chk(poe[6], 1'b0);
                chk(poe[4], 1'b0);
                chk(mac_clk, 1'b0);
                @(posedge clk_sys_i);
                rx_dibit_i <= 2'h3;
                carrier_i <= 1'b1;
                repeat (2) @(posedge clk_sys_i);
                #1 chk(po[5], 1'b1);
                @(posedge clk_sys_i);
                for (int k = 7; k > 0; k--) bit_in(SFD_PATTERN[k]);
                chk(rxd_o, 2'h0);
                bit_in(SFD_PATTERN[0]);
                repeat (4) @(posedge clk_sys_i);
                #1 chk(rxd_o, 2'h3);
                rd(ADDR_STATUS, 32'h10);
                mac_tx_en_i <= 1'b1;
                repeat (3) @(posedge clk_sys_i);
                #1 chk(rxd_o, 2'h0);
                @(posedge clk_sys_i);
                full_duplex_i <= 1'b1;
                repeat (3) @(posedge clk_sys_i);
                #1 chk(rxd_o, 2'h3);
                @(posedge clk_sys_i);
                carrier_i <= 1'b0;
                repeat (3) @(posedge clk_sys_i);
                #1 chk(po[5], 1'b0);
                chk(rxd_o, 2'h0);
                @(posedge clk_sys_i);
                {speed_fast_i, carrier_i} <= 2'b11;
                repeat (3) @(posedge clk_sys_i);
                #1 chk(rxd_o, 2'h3);
            end
            @(posedge clk_sys_i);
            {carrier_i, full_duplex_i, speed_fast_i, link_up_i, mac_tx_en_i} <= 5'h0;
        end
        give_verdict();
    end
endmodule : tb_prx_phy_rx_status
`default_nettype wire
